/* File: verilog/analog_and_regulator_control_regs.sv */
// analog and regulator control register bank in the crystal clock domain
//
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module analog_and_regulator_control_regs (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // register port
  input wire logic [15:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  // crystal clock enable
  output logic o_crystal_clk_en,
  // analog status from macros and pins
  input wire ana_regs_pkg::ana_status_t i_status,
  // analog controls
  output ana_regs_pkg::ana_ctrl_t o_ctrl,
  output logic o_lock_check_active,
  // regulators and clock gates
  output ana_regs_pkg::regu_t o_regu,
  output logic o_ad_filter_clock_gate,
  output logic o_radio_demod_clock_gate
);
  import ana_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // storage
  logic [15:0] cfg0_r, cfg1_r, cfg2_r, cfg3_r, rctl_r, rvolt_r;
  logic [15:0] cfg0_nxt, cfg1_nxt, cfg2_nxt, cfg3_nxt, rctl_nxt, rvolt_nxt;
  ana_status_t st_sync;
  logic lock_seen_r;
  logic lock_seen_nxt;
  logic chk_d_r;
  logic div_r;
  regu_t regu_nxt;
  logic latch_rise;
  logic [15:0] rd_mux;

  function automatic logic hit(input logic [15:0] a, input logic [15:0] off);
    hit = (a == off);
  endfunction

  status_sync #(.WIDTH(6)) u_sync (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_async(i_status),
    .o_sync(st_sync)
  );

  ////////////////////////////////////////////////////////////////////////
  // write decode, status bits held out of the stored value
  wire wr0 = i_wr && hit(i_addr, OFF_CFG_ZERO);
  wire wr1 = i_wr && hit(i_addr, OFF_CFG_ONE);
  wire wr2 = i_wr && hit(i_addr, OFF_CFG_TWO);
  wire wr3 = i_wr && hit(i_addr, OFF_CFG_THREE);
  wire wrc = i_wr && hit(i_addr, OFF_REG_CTRL);
  wire wrv = i_wr && hit(i_addr, OFF_REG_VOLT);
  assign cfg0_nxt = wr0 ? (i_wdata & MASK_CFG_ZERO) : cfg0_r;
  // button disable stored, pins read back
  assign cfg1_nxt = wr1 ? (i_wdata & MASK_CFG_ONE) : cfg1_r;
  assign cfg2_nxt = wr2 ? (i_wdata & MASK_CFG_TWO) : cfg2_r;
  assign cfg3_nxt = wr3 ? (i_wdata & MASK_CFG_THREE) : cfg3_r;
  assign rctl_nxt = wrc ? (i_wdata & MASK_REG_CTRL) : rctl_r;
  assign rvolt_nxt = wrv ? (i_wdata & MASK_REG_VOLT) : rvolt_r;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      cfg0_r <= RESET_VALUE;
      cfg1_r <= RESET_VALUE;
      cfg2_r <= RESET_VALUE;
      cfg3_r <= RESET_VALUE;
      rctl_r <= RESET_VALUE;
      rvolt_r <= RESET_VALUE;
    end else begin
      cfg0_r <= cfg0_nxt;
      cfg1_r <= cfg1_nxt;
      cfg2_r <= cfg2_nxt;
      cfg3_r <= cfg3_nxt;
      rctl_r <= rctl_nxt;
      rvolt_r <= rvolt_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // lock check: rise of init arms, status is lock held since
  wire chk_rise = cfg0_r[LOCK_CHECK_BIT] && !chk_d_r;
  assign lock_seen_nxt = chk_rise ? st_sync.vco_lock
                                  : (lock_seen_r && st_sync.vco_lock);
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      chk_d_r <= 1'b0;
      lock_seen_r <= 1'b0;
    end else begin
      chk_d_r <= cfg0_r[LOCK_CHECK_BIT];
      lock_seen_r <= lock_seen_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // prescaler: enable every cycle, or every other when set
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      div_r <= 1'b0;
      o_crystal_clk_en <= 1'b0;
    end else begin
      div_r <= ~div_r;
      o_crystal_clk_en <= cfg1_r[9] ? div_r : 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // regulator settings latched on the rising latch strobe
  assign latch_rise = wrc && i_wdata[LATCH_BIT] && !rctl_r[LATCH_BIT];
  // shutdown bits taken from the control word being written
  assign regu_nxt = latch_rise ? regu_t'{
      analog_supply_code: rvolt_r[14:10],
      io_supply_code: rvolt_r[9:5],
      core_supply_code: rvolt_r[4:0],
      serial_flash_supply_code: i_wdata[11:7],
      serial_flash_regulator_off: i_wdata[6],
      analog_regulator_off: i_wdata[2],
      io_regulator_off: i_wdata[1],
      core_regulator_off: i_wdata[0]} : o_regu;

  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_regu <= '0;
    end else begin
      o_regu <= regu_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // control outputs registered from the stored fields
  ana_ctrl_t ctrl_nxt;
  // enables; gain code passed as written
  // radio divider; usb; gains; vco fields
  assign ctrl_nxt = '{
      adc1_line_select: cfg0_r[10],
      adc2_line_select: cfg0_r[9],
      adc2_mic_select: cfg0_r[5],
      adc1_mic_select: cfg0_r[2],
      adc2_radio_select: cfg0_r[1],
      adc1_radio_select: cfg0_r[0],
      vco_lock_check_init: cfg0_r[LOCK_CHECK_BIT],
      button_reset_disable: cfg1_r[12],
      crystal_prescale: cfg1_r[9],
      control_adc_enable: cfg1_r[8],
      dac_enable: cfg1_r[6],
      dac_driver_enable: cfg1_r[3],
      dac_gain_code: cfg1_r[1:0],
      ground_buffer_protect_disable: cfg2_r[11],
      usb_transceiver_enable: cfg2_r[10],
      low_noise_amp_enable: cfg2_r[9],
      fast_vco_enable: cfg2_r[8],
      mic_amp_one_enable: cfg2_r[7],
      mic_amp_two_enable: cfg2_r[6],
      reference_level_select: cfg2_r[4],
      reference_power_enable: cfg2_r[3],
      adc_three_power: cfg2_r[2],
      adc_two_power: cfg2_r[1],
      adc_one_power: cfg2_r[0],
      usb_hs_clock_driver_enable: cfg3_r[15],
      usb_pad_bias_enable: cfg3_r[14],
      radio_divider_select: cfg3_r[13:12],
      vco_range_divider: cfg3_r[11:10],
      adc_two_gain: cfg3_r[9:7],
      adc_one_gain: cfg3_r[6:4],
      vco_center_trim: cfg3_r[3:0]};

  // clock gates: set cuts the clock
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_ctrl <= '0;
      o_lock_check_active <= 1'b0;
      o_ad_filter_clock_gate <= 1'b0;
      o_radio_demod_clock_gate <= 1'b0;
    end else begin
      o_ctrl <= ctrl_nxt;
      o_lock_check_active <= cfg0_r[LOCK_CHECK_BIT];
      o_ad_filter_clock_gate <= rctl_r[5];
      o_radio_demod_clock_gate <= rctl_r[4];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read mux with status bits merged in; unmapped reads zero
  wire [15:0] cfg0_rd = cfg0_r | (16'(lock_seen_r) << LOCK_STATUS_BIT);
  wire [15:0] cfg1_rd = cfg1_r
      | (16'(st_sync.supply_input_monitor) << SUPPLY_MON_BIT)
      | (16'(st_sync.power_button_state) << BUTTON_BIT)
      | (16'(st_sync.debug_pin_state) << DEBUG_PIN_BIT);
  wire [15:0] cfg2_rd = cfg2_r
      | (16'(st_sync.hw_debug_test_flag) << TEST_FLAG_BIT)
      | (16'(st_sync.ground_buffer_short_flag) << GND_SHORT_BIT);
  assign rd_mux = hit(i_addr, OFF_CFG_ZERO) ? cfg0_rd :
                  hit(i_addr, OFF_CFG_ONE) ? cfg1_rd :
                  hit(i_addr, OFF_CFG_TWO) ? cfg2_rd :
                  hit(i_addr, OFF_CFG_THREE) ? cfg3_r :
                  hit(i_addr, OFF_REG_CTRL) ? rctl_r :
                  hit(i_addr, OFF_REG_VOLT) ? rvolt_r : 16'h0000;

  // read data valid in the cycle after the strobe only
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else begin
      o_rdata <= i_rd ? rd_mux : 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // checks; every one is held off while reset stands
  // no latch, no change
  volt_hold_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !latch_rise |=> o_regu == $past(o_regu))
    else $error("regulator changed without latch");
  latch_apply_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    latch_rise |=> o_regu.core_supply_code == $past(rvolt_r[4:0]))
    else $error("latch did not apply core code");
  reg_off_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    latch_rise |=> {o_regu.analog_regulator_off, o_regu.io_regulator_off,
      o_regu.core_regulator_off} == $past(i_wdata[2:0]))
    else $error("regulator shutdown not latched");
  wr_read_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    wr3 ##1 (i_rd && hit(i_addr, OFF_CFG_THREE) && !wr3)
    |=> o_rdata == $past(cfg3_r))
    else $error("readback mismatch");
  rdata_idle_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_rd |=> o_rdata == 16'h0000)
    else $error("read data outside read cycle");
  ro_flag_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    cfg2_r[TEST_FLAG_BIT] == 1'b0)
    else $error("test flag stored");
  status_read_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_rd && hit(i_addr, OFF_CFG_ONE)
    |=> o_rdata[SUPPLY_MON_BIT] == $past(st_sync.supply_input_monitor))
    else $error("supply monitor not shown");
  short_flag_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    i_rd && hit(i_addr, OFF_CFG_TWO)
    |=> o_rdata[GND_SHORT_BIT] == $past(st_sync.ground_buffer_short_flag))
    else $error("short flag not shown");
  prescale_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    cfg1_r[9] && $past(cfg1_r[9]) && o_crystal_clk_en |=> !o_crystal_clk_en)
    else $error("prescaler not dividing");
  // steady enable; the release edge still shows the reset value
  no_div_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !i_rst && !cfg1_r[9] |=> o_crystal_clk_en)
    else $error("enable missing without prescale");
  lock_drop_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    !chk_rise && !st_sync.vco_lock |=> !lock_seen_r)
    else $error("lock status held without lock");
  gate_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    wrc ##1 !wrc |=> o_ad_filter_clock_gate == $past(i_wdata[5], 2))
    else $error("ad clock gate wrong");
  demod_gate_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 o_radio_demod_clock_gate == $past(rctl_r[4]))
    else $error("demodulator clock gate wrong");
  sync_path_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    $rose(st_sync.supply_input_monitor)
    |-> $past(i_status.supply_input_monitor, 2))
    else $error("sync latency wrong");
  select_pass_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 {o_ctrl.adc1_line_select, o_ctrl.adc2_line_select,
      o_ctrl.adc2_mic_select} == {$past(cfg0_r[10:9]), $past(cfg0_r[5])})
    else $error("input select wrong");
  dac_enable_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 {o_ctrl.control_adc_enable, o_ctrl.dac_enable,
      o_ctrl.dac_driver_enable} == {$past(cfg1_r[8]), $past(cfg1_r[6]),
      $past(cfg1_r[3])})
    else $error("analog enable wrong");
  pwr_follow_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 o_ctrl.adc_one_power == $past(cfg2_r[0]))
    else $error("adc power mismatch");
  ref_select_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 o_ctrl.reference_level_select == $past(cfg2_r[4]))
    else $error("reference select wrong");
  div_code_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 o_ctrl.radio_divider_select == $past(cfg3_r[13:12]))
    else $error("radio divider wrong");
  usb_enable_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 {o_ctrl.usb_hs_clock_driver_enable, o_ctrl.usb_pad_bias_enable}
      == $past(cfg3_r[15:14]))
    else $error("usb enable wrong");
  adc_gain_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 {o_ctrl.adc_two_gain, o_ctrl.adc_one_gain} == $past(cfg3_r[9:4]))
    else $error("adc gain wrong");
  vco_fields_a: assert property (@(posedge i_mclk) disable iff (i_rst)
    ##1 {o_ctrl.vco_range_divider, o_ctrl.vco_center_trim}
      == {$past(cfg3_r[11:10]), $past(cfg3_r[3:0])})
    else $error("vco field wrong");
  // main scenarios reached
  latch_cov: cover property (@(posedge i_mclk) disable iff (i_rst) latch_rise);
  lock_cov: cover property (@(posedge i_mclk) disable iff (i_rst)
    chk_rise ##[1:20] lock_seen_r);
  read_cov: cover property (@(posedge i_mclk) disable iff (i_rst)
    i_rd && hit(i_addr, OFF_CFG_ONE));
  prescale_cov: cover property (@(posedge i_mclk) disable iff (i_rst)
    cfg1_r[9] && !o_crystal_clk_en);
  gate_cov: cover property (@(posedge i_mclk) disable iff (i_rst)
    o_ad_filter_clock_gate && o_radio_demod_clock_gate);
endmodule // analog_and_regulator_control_regs

/* File: verilog/ana_regs_pkg.sv */
// package: offsets, field positions, reset values and types for the bank
package ana_regs_pkg;
  localparam logic [15:0] OFF_CFG_ONE = 16'hfecb;
  localparam logic [15:0] OFF_CFG_ZERO = 16'hfecc;
  localparam logic [15:0] OFF_REG_CTRL = 16'hfece;
  localparam logic [15:0] OFF_REG_VOLT = 16'hfed0;
  localparam logic [15:0] OFF_CFG_TWO = 16'hfed2;
  localparam logic [15:0] OFF_CFG_THREE = 16'hfed3;
  localparam logic [15:0] RESET_VALUE = 16'h0000;
  // bit positions of the read-only status bits, the lock check init bit and the latch strobe bit
  localparam int LOCK_CHECK_BIT = 3;
  localparam int LOCK_STATUS_BIT = 4;
  localparam int SUPPLY_MON_BIT = 14;
  localparam int BUTTON_BIT = 13;
  localparam int DEBUG_PIN_BIT = 10;
  localparam int TEST_FLAG_BIT = 13;
  localparam int GND_SHORT_BIT = 12;
  localparam int LATCH_BIT = 3;
  // software writable masks; status bits are excluded
  localparam logic [15:0] MASK_CFG_ZERO = 16'h063f & ~16'h0010;
  localparam logic [15:0] MASK_CFG_ONE = 16'h134b;
  localparam logic [15:0] MASK_CFG_TWO = 16'h0fdf;
  localparam logic [15:0] MASK_CFG_THREE = 16'hffff;
  localparam logic [15:0] MASK_REG_CTRL = 16'h0fff;
  localparam logic [15:0] MASK_REG_VOLT = 16'h7fff;
  // dac gain, radio divider and adc gain codes
  localparam logic [1:0] DAC_GAIN_0DB = 2'h0;
  localparam logic [1:0] DAC_GAIN_M12DB = 2'h1;
  localparam logic [1:0] DAC_GAIN_BAD = 2'h2;
  localparam logic [1:0] DAC_GAIN_M6DB = 2'h3;
  localparam logic [1:0] RADIO_DIV_16 = 2'h0;
  localparam logic [1:0] RADIO_DIV_RSVD = 2'h1;
  localparam logic [1:0] RADIO_DIV_20 = 2'h2;
  localparam logic [1:0] RADIO_DIV_24 = 2'h3;
  localparam logic [2:0] ADC_GAIN_20DB = 3'h1;
  localparam logic [2:0] ADC_GAIN_17DB = 3'h2;
  localparam logic [2:0] ADC_GAIN_14DB = 3'h4;
  localparam logic [2:0] ADC_GAIN_11DB = 3'h0;

  // analog status inputs from the macros and pins
  typedef struct packed {
    logic vco_lock;
    logic supply_input_monitor;
    logic power_button_state;
    logic debug_pin_state;
    logic hw_debug_test_flag;
    logic ground_buffer_short_flag;
  } ana_status_t;

  // analog front end controls
  typedef struct packed {
    logic adc1_line_select;
    logic adc2_line_select;
    logic adc2_mic_select;
    logic adc1_mic_select;
    logic adc2_radio_select;
    logic adc1_radio_select;
    logic vco_lock_check_init;
    logic button_reset_disable;
    logic crystal_prescale;
    logic control_adc_enable;
    logic dac_enable;
    logic dac_driver_enable;
    logic [1:0] dac_gain_code;
    logic ground_buffer_protect_disable;
    logic usb_transceiver_enable;
    logic low_noise_amp_enable;
    logic fast_vco_enable;
    logic mic_amp_one_enable;
    logic mic_amp_two_enable;
    logic reference_level_select;
    logic reference_power_enable;
    logic adc_three_power;
    logic adc_two_power;
    logic adc_one_power;
    logic usb_hs_clock_driver_enable;
    logic usb_pad_bias_enable;
    logic [1:0] radio_divider_select;
    logic [1:0] vco_range_divider;
    logic [2:0] adc_two_gain;
    logic [2:0] adc_one_gain;
    logic [3:0] vco_center_trim;
  } ana_ctrl_t;

  // latched regulator settings
  typedef struct packed {
    logic [4:0] analog_supply_code;
    logic [4:0] io_supply_code;
    logic [4:0] core_supply_code;
    logic [4:0] serial_flash_supply_code;
    logic serial_flash_regulator_off;
    logic analog_regulator_off;
    logic io_regulator_off;
    logic core_regulator_off;
  } regu_t;
endpackage

/* File: verilog/status_sync.sv */
// two-flop synchroniser bank for asynchronous status levels
`timescale 1ns/1ps
module status_sync #(
  parameter int WIDTH = 6
) (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // levels
  input wire logic [WIDTH-1:0] i_async,
  output logic [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta_r;

  // first stage is read only by the second stage
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      meta_r <= '0;
      o_sync <= '0;
    end else begin
      meta_r <= i_async;
      o_sync <= meta_r;
    end
  end
endmodule // status_sync

/* File: tb/ana_front_model.sv */
// stand-in for the analog macros and pins that feed the status bits
`timescale 1ns/1ps
module ana_front_model (
  // clock
  input wire logic i_mclk,
  // levels commanded by the bench
  input wire logic i_lock_ok,
  input wire logic [4:0] i_pins,
  // controls from the bank
  input wire ana_regs_pkg::ana_ctrl_t i_ctrl,
  // status towards the bank
  output ana_regs_pkg::ana_status_t o_status
);
  import ana_regs_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // lock only with the fast vco powered, a dead vco never reports lock
  // lock follows vco
  always_ff @(posedge i_mclk) begin
    o_status.vco_lock <= i_lock_ok & i_ctrl.fast_vco_enable;
    o_status.supply_input_monitor <= i_pins[4];
    o_status.power_button_state <= i_pins[3];
    o_status.debug_pin_state <= i_pins[2];
    o_status.hw_debug_test_flag <= i_pins[1];
    o_status.ground_buffer_short_flag <= i_pins[0];
  end
endmodule // ana_front_model

/* File: tb/tb_top.sv */
// self-checking bench for the analog and regulator control bank
`timescale 1ns/1ps
module tb_top;
  import ana_regs_pkg::*;
  localparam logic [15:0] OFFS [6] = '{OFF_CFG_ONE, OFF_CFG_ZERO,
    OFF_REG_CTRL, OFF_REG_VOLT, OFF_CFG_TWO, OFF_CFG_THREE};
  localparam logic [15:0] MASKS [6] = '{MASK_CFG_ONE, MASK_CFG_ZERO,
    MASK_REG_CTRL, MASK_REG_VOLT, MASK_CFG_TWO, MASK_CFG_THREE};
  // control cases: input selects, enables, gain and divider codes; trim code stays zero
  localparam logic [15:0] COFF [10] = '{OFF_CFG_ZERO, OFF_CFG_ZERO,
    OFF_CFG_ONE, OFF_CFG_ONE, OFF_CFG_ONE, OFF_CFG_TWO, OFF_CFG_TWO,
    OFF_CFG_THREE, OFF_CFG_THREE, OFF_CFG_THREE};
  localparam logic [15:0] CDAT [10] = '{16'h0421, 16'h0206, 16'h1149,
    16'h0203, 16'h1040, 16'h0a95, 16'h054a, 16'h8090, 16'h6d20, 16'h0240};
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic [15:0] i_addr = 16'h0000;
  logic [15:0] i_wdata = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic lock_ok = 1'b0;
  logic [4:0] pins = 5'h00;
  logic [15:0] o_rdata;
  logic o_crystal_clk_en, o_lock_check_active;
  logic o_ad_filter_clock_gate, o_radio_demod_clock_gate;
  ana_status_t st;
  ana_ctrl_t o_ctrl;
  regu_t o_regu;
  int failures = 0;
  int n_tests = 0;

  always #10 i_mclk = ~i_mclk;

  analog_and_regulator_control_regs analog_and_regulator_control_regs_inst (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_crystal_clk_en(o_crystal_clk_en), .i_status(st), .o_ctrl(o_ctrl),
    .o_lock_check_active(o_lock_check_active), .o_regu(o_regu),
    .o_ad_filter_clock_gate(o_ad_filter_clock_gate),
    .o_radio_demod_clock_gate(o_radio_demod_clock_gate));
  ana_front_model ana_front_model_inst (.i_mclk(i_mclk),
    .i_lock_ok(lock_ok), .i_pins(pins), .i_ctrl(o_ctrl), .o_status(st));

  ////////////////////////////////////////////////////////////////////////////
  // shared tasks
  task chk(input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [15:0] a, input logic [15:0] d);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_mclk);
    i_wr <= 1'b0;
  endtask
  // read data stands only in the cycle after the strobe; the strobe goes
  // up at once, so a read may follow a write with no idle cycle
  task rchk(input logic [15:0] a, input logic [15:0] e);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1;
    chk(64'(o_rdata), 64'(e));
  endtask
  task settle(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  function automatic regu_t mk(input logic [15:0] v, input logic [15:0] c);
    return {v[14:10], v[9:5], v[4:0], c[11:7], c[6], c[2], c[1], c[0]};
  endfunction
  task end_of_test;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence; flash code field is free, no embedded flash in use
  // flash field free
  initial begin : main
    logic [15:0] d;
    int cnt;
    regu_t er;
    repeat (16) @(posedge i_mclk);
    i_rst <= 1'b0;
    for (int i = 0; i < 6; i++) rchk(OFFS[i], RESET_VALUE);
    chk(64'(o_ctrl), 64'h0);
    chk(64'(o_regu), 64'h0);
    for (int i = 0; i < 6; i++) begin
      wr(OFFS[i], 16'hffff);
      rchk(OFFS[i], MASKS[i]);
    end
    for (int i = 0; i < 6; i++) wr(OFFS[i], 16'h0000);
    // unmapped places hold nothing
    wr(16'hfecd, 16'hffff);
    rchk(16'hfecd, 16'h0000);
    rchk(16'hfed1, 16'h0000);
    rchk(OFF_CFG_ZERO, 16'h0000);
    // status levels, written zeros cannot hide them
    for (int p = 0; p < 2; p++) begin
      pins <= p ? 5'b01010 : 5'b10101;
      settle(5);
      rchk(OFF_CFG_ONE, {1'b0, pins[4:3], 2'b00, pins[2], 10'h0});
      rchk(OFF_CFG_TWO, {2'b00, pins[1:0], 12'h0});
    end
    pins <= 5'h00;
    // control fields reach the analog side one cycle after the write
    for (int i = 0; i < 10; i++) begin
      d = CDAT[i];
      wr(COFF[i], d);
      settle(2);
      case (COFF[i])
        OFF_CFG_ZERO: chk(64'({o_ctrl.adc1_line_select,
          o_ctrl.adc2_line_select, o_ctrl.adc2_mic_select,
          o_ctrl.adc1_mic_select, o_ctrl.adc2_radio_select,
          o_ctrl.adc1_radio_select}),
          64'({d[10], d[9], d[5], d[2], d[1], d[0]}));
        OFF_CFG_ONE: begin
          chk(64'({o_ctrl.button_reset_disable, o_ctrl.crystal_prescale,
            o_ctrl.control_adc_enable, o_ctrl.dac_enable,
            o_ctrl.dac_driver_enable, o_ctrl.dac_gain_code}),
            64'({d[12], d[9], d[8], d[6], d[3], d[1:0]}));
          cnt = 0;
          repeat (4) begin
            @(posedge i_mclk);
            #1;
            cnt += int'(o_crystal_clk_en);
          end
          chk(64'(cnt), d[9] ? 64'd2 : 64'd4);
        end
        OFF_CFG_TWO: chk(64'({o_ctrl.ground_buffer_protect_disable,
          o_ctrl.usb_transceiver_enable, o_ctrl.low_noise_amp_enable,
          o_ctrl.fast_vco_enable, o_ctrl.mic_amp_one_enable,
          o_ctrl.mic_amp_two_enable, o_ctrl.reference_level_select,
          o_ctrl.reference_power_enable, o_ctrl.adc_three_power,
          o_ctrl.adc_two_power, o_ctrl.adc_one_power}),
          64'({d[11:6], d[4:0]}));
        default: chk(64'({o_ctrl.usb_hs_clock_driver_enable,
          o_ctrl.usb_pad_bias_enable, o_ctrl.radio_divider_select,
          o_ctrl.vco_range_divider, o_ctrl.adc_two_gain,
          o_ctrl.adc_one_gain, o_ctrl.vco_center_trim}),
          64'(d));
      endcase
    end
    // lock check: set then clear, status holds only while locked
    wr(OFF_CFG_TWO, 16'h0100);
    for (int k = 0; k < 2; k++) begin
      lock_ok <= (k == 0);
      settle(5);
      wr(OFF_CFG_ZERO, 16'h0008);
      settle(2);
      chk(64'({o_lock_check_active, o_ctrl.vco_lock_check_init}), 64'h3);
      wr(OFF_CFG_ZERO, 16'h0000);
      rchk(OFF_CFG_ZERO, k ? 16'h0000 : 16'h0010);
    end
    lock_ok <= 1'b1;
    settle(5);
    wr(OFF_CFG_ZERO, 16'h0008);
    wr(OFF_CFG_ZERO, 16'h0000);
    lock_ok <= 1'b0;
    settle(5);
    rchk(OFF_CFG_ZERO, 16'h0000);
    // regulator settings apply only on a rising latch strobe
    er = mk(16'h0000, 16'hffff);
    wr(OFF_REG_VOLT, 16'h5a5a);
    wr(OFF_REG_CTRL, 16'h0ac7);
    settle(2);
    chk(64'(o_regu), 64'(er));
    wr(OFF_REG_CTRL, 16'h0acf);
    settle(2);
    er = mk(16'h5a5a, 16'h0acf);
    chk(64'(o_regu), 64'(er));
    wr(OFF_REG_VOLT, 16'h0000);
    wr(OFF_REG_CTRL, 16'h0acf);
    wr(OFF_REG_CTRL, 16'h0000);
    settle(2);
    chk(64'(o_regu), 64'(er));
    wr(OFF_REG_CTRL, 16'h0038);
    settle(2);
    chk(64'(o_regu), 64'(mk(16'h0000, 16'h0038)));
    chk(64'({o_ad_filter_clock_gate, o_radio_demod_clock_gate}),
      64'h3);
    wr(OFF_REG_CTRL, 16'h0010);
    settle(2);
    chk(64'({o_ad_filter_clock_gate, o_radio_demod_clock_gate}),
      64'h1);
    // a second reset in mid-run clears the bank again
    wr(OFF_CFG_THREE, 16'hffff);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_rst <= 1'b0;
    rchk(OFF_CFG_THREE, RESET_VALUE);
    end_of_test();
  end

  ////////////////////////////////////////////////////////////////////////////
  // watchdog, the sequence needs well under a thousand cycles
  initial begin : watchdog
    #200000;
    failures++;
    end_of_test();
  end
endmodule // tb_top
